// ---- tx_byte_ram.sv ----
// Byte memory holding every endpoint's transmit FIFO
module tx_byte_ram #(
  parameter int AW = 10
) (
  input  wire logic          clk,     // Core clock
  input  wire logic          ce,      // Clock enable
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] waddr,   // Write address
  input  wire logic [7:0]    wdata,   // Write byte
  input  wire logic          re,      // Read strobe
  input  wire logic [AW-1:0] raddr,   // Read address
  output logic      [7:0]    rdata_r  // Registered read byte
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata_r <= mem[raddr];
    end
  end

endmodule

// ---- usb_endpoint_status_and_tx_load_bench.sv ----
// Self-checking bench for the endpoint status and transmit load block
module usb_endpoint_status_and_tx_load_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, irq, hs_ack, hs_nak, hs_stall;
  logic [7:0]  cond = 8'h80;
  logic [6:0]  function_address;
  logic [3:0]  endpoint_select_index, txn_ep, tx_rd_ep, tx_set_ep;
  logic        txn_end, txn_setup, txn_iso, txn_crc_err, txn_stuff_err;
  logic        txn_fifo_err, sof, usb_reset, tx_rd_en, tx_set_done;
  logic [5:0]  tx_rd_ptr;
  logic [7:0]  tx_rd_data, b;
  logic [9:0]  tx_rd_count;
  int          errors = 0;
  int          compares = 0;
  // Endpoint conditions that each make an OUT void
  localparam logic [7:0] VOID_T [8] = '{8'h00, 8'hc0, 8'ha0, 8'h98,
                                        8'h8c, 8'h94, 8'h82, 8'h81};
  localparam logic [4:0] ERR_T [4] = '{5'h04, 5'h02, 5'h01, 5'h14};

  always #5 clk = ~clk;

  usb_ep_regs usb_ep_regs_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .txn_end(txn_end), .txn_ep(txn_ep),
    .txn_setup(txn_setup), .txn_iso(txn_iso), .txn_crc_err(txn_crc_err),
    .txn_stuff_err(txn_stuff_err), .txn_fifo_err(txn_fifo_err),
    .sof(sof), .usb_reset(usb_reset), .rx_input_enable(cond[7]),
    .rx_stall(cond[6]), .setup_received_flag(cond[5]),
    .rx_dataset_count(cond[4:3]), .rx_single_packet_mode(cond[2]),
    .rx_underrun_flag(cond[1]), .rx_overrun_flag(cond[0]),
    .hs_ack(hs_ack), .hs_nak(hs_nak), .hs_stall(hs_stall),
    .function_address(function_address),
    .endpoint_select_index(endpoint_select_index),
    .tx_rd_en(tx_rd_en), .tx_rd_ep(tx_rd_ep), .tx_rd_ptr(tx_rd_ptr),
    .tx_rd_data(tx_rd_data), .tx_rd_count(tx_rd_count),
    .tx_set_done(tx_set_done), .tx_set_ep(tx_set_ep));

  usb_host_model usb_host_model_inst (.clk(clk), .txn_end(txn_end),
    .txn_ep(txn_ep), .txn_setup(txn_setup), .txn_iso(txn_iso),
    .txn_crc_err(txn_crc_err), .txn_stuff_err(txn_stuff_err),
    .txn_fifo_err(txn_fifo_err), .sof(sof), .usb_reset(usb_reset),
    .tx_rd_en(tx_rd_en), .tx_rd_ep(tx_rd_ep), .tx_rd_ptr(tx_rd_ptr),
    .tx_rd_data(tx_rd_data), .tx_set_done(tx_set_done),
    .tx_set_ep(tx_set_ep));

  // ==========================================================
  // Verdict and comparison
  task automatic close_out();
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ==========================================================
  // Avalon access: hold request until waitrequest low at an edge
  task automatic acc(input logic wr, input logic [5:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    logic w;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    w = 1'b1;
    n = 0;
    while (w !== 1'b0) begin
      @(posedge clk);
      w = avs_waitrequest;
      rd = avs_readdata;
      n++;
      if (n > 50) begin
        errors++;
        close_out();
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wreg(input logic [5:0] idx, input logic [31:0] v);
    logic [31:0] x;
    acc(1'b1, idx, v, x);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] e);
    logic [31:0] x;
    acc(1'b0, idx, 32'h0, x);
    chk($sformatf("register %h", idx), x, e);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #200us;
    errors++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(usb_ep_pkg::FUNCTION_ADDRESS_IDX, 32'h0);
    rchk(usb_ep_pkg::RX_STAT_IDX, 32'h0);
    rchk(usb_ep_pkg::TX_CNT_HI_IDX, 32'h0);
    rchk(6'h3f, 32'h0);
    wreg(usb_ep_pkg::FUNCTION_ADDRESS_IDX, 32'hff);
    rchk(usb_ep_pkg::FUNCTION_ADDRESS_IDX, 32'h7f);
    wreg(usb_ep_pkg::FUNCTION_ADDRESS_IDX, 32'h2a);
    wreg(usb_ep_pkg::MISC_CTL_IDX, 32'h0);
    usb_host_model_inst.pulse(1, 4'h0);
    @(negedge clk);
    chk("address kept", function_address, 32'h2a);
    wreg(usb_ep_pkg::MISC_CTL_IDX, 32'h1);
    usb_host_model_inst.pulse(1, 4'h0);
    rchk(usb_ep_pkg::FUNCTION_ADDRESS_IDX, 32'h0);
    // Transmit load on endpoint 2, then isolation from endpoint 3
    wreg(usb_ep_pkg::EP_SEL_IDX, 32'h2);
    for (int i = 0; i < 3; i++) begin
      wreg(usb_ep_pkg::TX_DATA_IDX, 32'ha1 + i);
    end
    wreg(usb_ep_pkg::TX_CNT_HI_IDX, 32'hff);
    wreg(usb_ep_pkg::TX_CNT_LO_IDX, 32'h03);
    rchk(usb_ep_pkg::TX_CNT_HI_IDX, 32'h03);
    rchk(usb_ep_pkg::TX_CNT_LO_IDX, 32'h03);
    rchk(usb_ep_pkg::TX_SETS_IDX, 32'h1);
    for (int i = 0; i < 3; i++) begin
      usb_host_model_inst.fetch(4'h2, 6'(i), b);
      chk("fifo byte", b, 32'ha1 + i);
    end
    @(negedge clk);
    chk("fetch count", tx_rd_count, 32'h303);
    wreg(usb_ep_pkg::EP_SEL_IDX, 32'h3);
    @(negedge clk);
    chk("endpoint index", endpoint_select_index, 32'h3);
    rchk(usb_ep_pkg::TX_CNT_LO_IDX, 32'h0);
    rchk(usb_ep_pkg::TX_SETS_IDX, 32'h0);
    wreg(usb_ep_pkg::EP_SEL_IDX, 32'h2);
    for (int i = 0; i < 3; i++) wreg(usb_ep_pkg::TX_CNT_LO_IDX, 32'h03);
    rchk(usb_ep_pkg::TX_SETS_IDX, 32'h3);
    usb_host_model_inst.pulse(2, 4'h2);
    rchk(usb_ep_pkg::TX_SETS_IDX, 32'h2);
    wreg(usb_ep_pkg::EP_SEL_IDX, 32'h4);
    wreg(usb_ep_pkg::TX_CNT_HI_IDX, 32'h0);
    wreg(usb_ep_pkg::TX_CNT_LO_IDX, 32'h0);
    rchk(usb_ep_pkg::TX_CNT_LO_IDX, 32'h0);
    rchk(usb_ep_pkg::TX_SETS_IDX, 32'h1);
    // Receive status on endpoint 1
    wreg(usb_ep_pkg::EP_SEL_IDX, 32'h1);
    foreach (VOID_T[i]) begin
      usb_host_model_inst.txn(4'h1, 5'h00);
      rchk(usb_ep_pkg::RX_STAT_IDX, 32'h1);
      rchk(usb_ep_pkg::INT_STAT_IDX, 32'h2);
      @(posedge clk) cond <= VOID_T[i];
      usb_host_model_inst.txn(4'h1, 5'h00);
      rchk(usb_ep_pkg::RX_STAT_IDX, 32'h5);
      rchk(usb_ep_pkg::INT_STAT_IDX, 32'h0);
      @(posedge clk) cond <= 8'h80;
    end
    foreach (ERR_T[i]) begin
      usb_host_model_inst.txn(4'h1, 5'h00);
      rchk(usb_ep_pkg::RX_STAT_IDX, 32'h1);
      usb_host_model_inst.txn(4'h1, ERR_T[i]);
      rchk(usb_ep_pkg::RX_STAT_IDX, 32'h2);
      rchk(usb_ep_pkg::INT_STAT_IDX, 32'h2);
    end
    usb_host_model_inst.txn(4'h1, 5'h08);
    rchk(usb_ep_pkg::RX_STAT_IDX, 32'h2);
    usb_host_model_inst.pulse(0, 4'h0);
    rchk(usb_ep_pkg::RX_STAT_IDX, 32'h1);
    rchk(usb_ep_pkg::INT_STAT_IDX, 32'h2);
    // Interrupt enabled, cleared by read, then masked
    wreg(usb_ep_pkg::INT_MASK_IDX, 32'h2);
    usb_host_model_inst.txn(4'h1, 5'h00);
    @(negedge clk);
    chk("irq raised", irq, 32'h1);
    rchk(usb_ep_pkg::INT_STAT_IDX, 32'h2);
    @(negedge clk);
    chk("irq cleared", irq, 32'h0);
    wreg(usb_ep_pkg::INT_MASK_IDX, 32'h0);
    usb_host_model_inst.txn(4'h1, 5'h00);
    @(negedge clk);
    chk("irq masked", irq, 32'h0);
    rchk(usb_ep_pkg::INT_STAT_IDX, 32'h2);
    // Held setup answers NAK even while stalled
    @(posedge clk) cond <= 8'he0;
    @(negedge clk);
    chk("nak", {hs_ack, hs_nak, hs_stall}, 32'h2);
    close_out();
  end
endmodule

// ---- usb_ep_pkg.sv ----
// Constants shared by the endpoint status and transmit load block
package usb_ep_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] TX_DATA_IDX   = 6'h00;
  localparam logic [5:0] TX_CNT_LO_IDX = 6'h01;
  localparam logic [5:0] TX_CNT_HI_IDX = 6'h02;
  localparam logic [5:0] RX_STAT_IDX   = 6'h0d;
  localparam logic [5:0] FUNCTION_ADDRESS_IDX     = 6'h10;
  localparam logic [5:0] INT_STAT_IDX  = 6'h20;
  localparam logic [5:0] INT_MASK_IDX  = 6'h21;
  localparam logic [5:0] MISC_CTL_IDX  = 6'h22;
  localparam logic [5:0] EP_SEL_IDX    = 6'h23;
  localparam logic [5:0] TX_SETS_IDX   = 6'h24;

  // ==========================================================
  // Field positions and widths
  localparam int RX_ACK_BIT   = 0;
  localparam int RX_ERR_BIT   = 1;
  localparam int RX_VOID_BIT  = 2;
  localparam int RESET_CLEARS_ADDRESS_FEATURE_BIT     = 0;
  localparam int FUNCTION_ADDRESS_W      = 7;
  localparam int CNT_W        = 10;
  localparam int CNT_HI_W     = 2;
  localparam int SETS_W       = 2;

  // ==========================================================
  // Reset values and data-set limits
  localparam logic [6:0]  FUNCTION_ADDRESS_RST = 7'h00;
  localparam logic [9:0]  CNT_RST   = 10'h000;
  localparam logic [1:0]  SETS_RST  = 2'h0;
  localparam logic [1:0]  SETS_FULL = 2'h3;
  localparam logic [15:0] MASK_RST  = 16'h0000;

  // ==========================================================
  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

// ---- usb_ep_regs.sv ----
// Endpoint receive status, function address and transmit FIFO loading
module usb_ep_regs #(
  parameter int NEP = 16,  // Endpoints
  parameter int FAW = 6    // Log2 of FIFO bytes per endpoint
) (
  input  wire logic             clk,              // 100 MHz clock
  input  wire logic             rst_b,            // Async reset, low
  input  wire logic             ce,               // Clock enable
  input  wire logic [7:0]       avs_address,      // Byte address
  input  wire logic             avs_read,         // Read request
  input  wire logic             avs_write,        // Write request
  input  wire logic [31:0]      avs_writedata,    // Write data
  output logic      [31:0]      avs_readdata,     // Read data
  output logic                  avs_waitrequest,  // Stall
  output logic                  irq,              // Level interrupt
  input  wire logic             txn_end,          // Transaction end
  input  wire logic [3:0]       txn_ep,           // Transaction endpoint
  input  wire logic             txn_setup,        // SETUP, else OUT
  input  wire logic             txn_iso,          // Isochronous
  input  wire logic             txn_crc_err,      // CRC failure
  input  wire logic             txn_stuff_err,    // Bit stuffing error
  input  wire logic             txn_fifo_err,     // Over/underrun in rx
  input  wire logic             sof,              // Start of frame
  input  wire logic             usb_reset,        // Bus reset seen
  input  wire logic             rx_input_enable,  // Endpoint rx enable
  input  wire logic             rx_stall,         // Endpoint stalled
  input  wire logic             setup_received_flag, // Setup held
  input  wire logic [1:0]       rx_dataset_count, // Rx sets in use
  input  wire logic             rx_single_packet_mode, // Single set
  input  wire logic             rx_underrun_flag, // Rx underrun
  input  wire logic             rx_overrun_flag,  // Rx overrun
  output logic                  hs_ack,           // Answer ACK
  output logic                  hs_nak,           // Answer NAK
  output logic                  hs_stall,         // Answer STALL
  output logic [6:0]            function_address, // Device address
  output logic [3:0]            endpoint_select_index, // Selected ep
  input  wire logic             tx_rd_en,         // Tx byte fetch
  input  wire logic [3:0]       tx_rd_ep,         // Tx endpoint
  input  wire logic [FAW-1:0]   tx_rd_ptr,        // Tx read pointer
  output logic      [7:0]       tx_rd_data,       // Fetched byte
  output logic      [9:0]       tx_rd_count,      // Count of tx_rd_ep
  input  wire logic             tx_set_done,      // Set sent, pulse
  input  wire logic [3:0]       tx_set_ep         // Endpoint of set
);

  // ==========================================================
  // State
  usb_ep_pkg::bus_state_t bus_r, bus_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic [NEP-1:0] void_r, void_nxt, err_r, err_nxt, ack_r, ack_nxt;
  logic [NEP-1:0] pend_r, pend_nxt, pvoid_r, pvoid_nxt;
  logic [NEP-1:0] perr_r, perr_nxt, pack_r, pack_nxt;
  logic [NEP-1:0] ist_r, ist_nxt, msk_r, msk_nxt;
  logic [6:0]    function_address_r, function_address_nxt;
  logic          reset_clears_address_feature_r, reset_clears_address_feature_nxt;
  logic [3:0]    sel_r, sel_nxt;
  logic [9:0]    cnt_r  [NEP];
  logic [9:0]    cnt_nxt [NEP];
  logic [1:0]    sets_r [NEP];
  logic [1:0]    sets_nxt [NEP];
  logic [FAW-1:0] wptr_r [NEP];
  logic [FAW-1:0] wptr_nxt [NEP];
  logic [9:0]    rcnt_r, rcnt_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [NEP-1:0] ep_bit(input logic [3:0] ep);
    ep_bit = '0;
    ep_bit[ep] = 1'b1;
  endfunction

  function automatic logic hit(input logic [5:0] idx);
    hit = (avs_address == {idx, 2'b00});
  endfunction

  // ==========================================================
  // Bus handshake: one wait state, act on the accepting edge
  logic req, acc, wr_acc, rd_acc;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & (bus_r != usb_ep_pkg::BUS_ACK);
  assign acc = req & (bus_r == usb_ep_pkg::BUS_ACK);
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  assign avs_readdata = rdata_r;

  // Handshake state
  always_comb begin
    bus_nxt = usb_ep_pkg::BUS_IDLE;
    if (req && bus_r == usb_ep_pkg::BUS_IDLE) begin
      bus_nxt = usb_ep_pkg::BUS_ACK;
    end
  end

  // ==========================================================
  // Handshake choice for the current transaction
  logic void_cond, err_cond;
  always_comb begin
    void_cond = !rx_input_enable || rx_stall || setup_received_flag ||
                (rx_dataset_count == 2'b11) ||
                (rx_dataset_count != 2'b00 && rx_single_packet_mode) ||
                rx_underrun_flag || rx_overrun_flag;
    err_cond  = txn_crc_err || txn_stuff_err || txn_fifo_err;
  end

  // NAK while a setup is held, even when stalled
  always_comb begin
    hs_nak   = setup_received_flag ||
               (!txn_setup && void_cond && !rx_stall);
    hs_stall = !setup_received_flag && rx_stall && !txn_setup;
    hs_ack   = !hs_nak && !hs_stall && !err_cond;
  end

  // ==========================================================
  // Receive status flags, iso results held until SOF
  always_comb begin
    void_nxt = void_r;
    err_nxt  = err_r;
    ack_nxt  = ack_r;
    pend_nxt = pend_r;
    pvoid_nxt = pvoid_r;
    perr_nxt = perr_r;
    pack_nxt = pack_r;
    if (sof) begin
      for (int i = 0; i < NEP; i++) begin
        if (pend_r[i]) begin
          void_nxt[i] = pvoid_r[i];
          err_nxt[i]  = pvoid_r[i] ? err_r[i] : perr_r[i];
          ack_nxt[i]  = pvoid_r[i] ? ack_r[i] : pack_r[i];
        end
      end
      pend_nxt = '0;
    end
    if (txn_end) begin
      if (txn_iso && !txn_setup) begin
        pend_nxt[txn_ep]  = 1'b1;
        pvoid_nxt[txn_ep] = void_cond;
        perr_nxt[txn_ep]  = !void_cond && err_cond;
        pack_nxt[txn_ep]  = !void_cond && !err_cond;
      end else begin
        if (!txn_setup) begin
          void_nxt[txn_ep] = void_cond;
        end
        if (txn_setup || !void_cond) begin
          err_nxt[txn_ep] = err_cond;
          ack_nxt[txn_ep] = !err_cond;
        end
      end
    end
  end

  // ==========================================================
  // Interrupt status: done bits set by results, read clears
  logic [NEP-1:0] done_set;
  always_comb begin
    done_set = '0;
    if (sof) begin
      done_set = pend_r & (perr_r | pack_r);
    end
    if (txn_end && !txn_iso && (txn_setup || !void_cond)) begin
      done_set = done_set | ep_bit(txn_ep);
    end
    ist_nxt = ist_r;
    if (rd_acc && hit(usb_ep_pkg::INT_STAT_IDX)) begin
      ist_nxt = ist_r & ~rdata_r[NEP-1:0]; // Only bits reported
    end
    ist_nxt = ist_nxt | done_set;
  end
  assign irq = |(ist_r & msk_r);

  // ==========================================================
  // Control registers
  always_comb begin
    function_address_nxt = function_address_r;
    reset_clears_address_feature_nxt  = reset_clears_address_feature_r;
    sel_nxt   = sel_r;
    msk_nxt   = msk_r;
    if (wr_acc && hit(usb_ep_pkg::FUNCTION_ADDRESS_IDX)) begin
      function_address_nxt = avs_writedata[usb_ep_pkg::FUNCTION_ADDRESS_W-1:0];
    end
    if (wr_acc && hit(usb_ep_pkg::MISC_CTL_IDX)) begin
      reset_clears_address_feature_nxt = avs_writedata[usb_ep_pkg::RESET_CLEARS_ADDRESS_FEATURE_BIT];
    end
    if (wr_acc && hit(usb_ep_pkg::EP_SEL_IDX)) begin
      sel_nxt = avs_writedata[3:0];
    end
    if (wr_acc && hit(usb_ep_pkg::INT_MASK_IDX)) begin
      msk_nxt = avs_writedata[NEP-1:0];
    end
    if (usb_reset && reset_clears_address_feature_r) begin
      function_address_nxt = usb_ep_pkg::FUNCTION_ADDRESS_RST;
    end
  end
  assign function_address      = function_address_r;
  assign endpoint_select_index = sel_r;

  // ==========================================================
  // Transmit loading, routed to the selected endpoint
  logic dat_wr, lo_wr, hi_wr;
  assign dat_wr = wr_acc && hit(usb_ep_pkg::TX_DATA_IDX) &&
                  (sets_r[sel_r] != usb_ep_pkg::SETS_FULL);
  assign lo_wr = wr_acc && hit(usb_ep_pkg::TX_CNT_LO_IDX);
  assign hi_wr = wr_acc && hit(usb_ep_pkg::TX_CNT_HI_IDX);

  // Per-endpoint pointers, counts and data-set counts
  always_comb begin
    for (int i = 0; i < NEP; i++) begin
      wptr_nxt[i] = wptr_r[i];
      cnt_nxt[i]  = cnt_r[i];
      sets_nxt[i] = sets_r[i];
      if (sel_r == 4'(i)) begin
        if (dat_wr) begin
          wptr_nxt[i] = wptr_r[i] + 1'b1;
        end
        if (hi_wr) begin
          cnt_nxt[i][9:8] = avs_writedata[1:0];
        end
        if (lo_wr) begin
          cnt_nxt[i][7:0] = avs_writedata[7:0];
          if (sets_r[i] != usb_ep_pkg::SETS_FULL) begin
            sets_nxt[i] = sets_r[i] + 1'b1;
          end
        end
      end
      if (tx_set_done && tx_set_ep == 4'(i) &&
          sets_nxt[i] != usb_ep_pkg::SETS_RST) begin
        sets_nxt[i] = sets_nxt[i] - 1'b1;
      end
    end
    rcnt_nxt = cnt_r[tx_rd_ep];
  end
  assign tx_rd_count = rcnt_r;

  tx_byte_ram #(
    .AW (FAW + 4)
  ) u_ram (
    .clk     (clk),
    .ce      (ce),
    .we      (dat_wr),
    .waddr   ({sel_r, wptr_r[sel_r]}),
    .wdata   (avs_writedata[7:0]),
    .re      (tx_rd_en),
    .raddr   ({tx_rd_ep, tx_rd_ptr}),
    .rdata_r (tx_rd_data)
  );

  // ==========================================================
  // Read data, captured during the wait state
  always_comb begin
    rdata_nxt = rdata_r;
    if (req && bus_r == usb_ep_pkg::BUS_IDLE) begin
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address[7:2])
        usb_ep_pkg::TX_CNT_LO_IDX: rdata_nxt[7:0] = cnt_r[sel_r][7:0];
        usb_ep_pkg::TX_CNT_HI_IDX: rdata_nxt[1:0] = cnt_r[sel_r][9:8];
        usb_ep_pkg::RX_STAT_IDX: begin
          rdata_nxt[usb_ep_pkg::RX_VOID_BIT] = void_r[sel_r];
          rdata_nxt[usb_ep_pkg::RX_ERR_BIT]  = err_r[sel_r];
          rdata_nxt[usb_ep_pkg::RX_ACK_BIT]  = ack_r[sel_r];
        end
        usb_ep_pkg::FUNCTION_ADDRESS_IDX:    rdata_nxt[6:0] = function_address_r;
        usb_ep_pkg::INT_STAT_IDX: rdata_nxt[NEP-1:0] = ist_r;
        usb_ep_pkg::INT_MASK_IDX: rdata_nxt[NEP-1:0] = msk_r;
        usb_ep_pkg::MISC_CTL_IDX: rdata_nxt[usb_ep_pkg::RESET_CLEARS_ADDRESS_FEATURE_BIT] = reset_clears_address_feature_r;
        usb_ep_pkg::EP_SEL_IDX:   rdata_nxt[3:0] = sel_r;
        usb_ep_pkg::TX_SETS_IDX:  rdata_nxt[1:0] = sets_r[sel_r];
        default:                  rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_r   <= usb_ep_pkg::BUS_IDLE;
      rdata_r <= 32'h0000_0000;
      void_r  <= '0;
      err_r   <= '0;
      ack_r   <= '0;
      pend_r  <= '0;
      pvoid_r <= '0;
      perr_r  <= '0;
      pack_r  <= '0;
      ist_r   <= '0;
      msk_r   <= usb_ep_pkg::MASK_RST;
      function_address_r <= usb_ep_pkg::FUNCTION_ADDRESS_RST;
      reset_clears_address_feature_r  <= 1'b0;
      sel_r   <= 4'h0;
      rcnt_r  <= usb_ep_pkg::CNT_RST;
      for (int i = 0; i < NEP; i++) begin
        cnt_r[i]  <= usb_ep_pkg::CNT_RST;
        sets_r[i] <= usb_ep_pkg::SETS_RST;
        wptr_r[i] <= '0;
      end
    end else if (ce) begin
      bus_r   <= bus_nxt;
      rdata_r <= rdata_nxt;
      void_r  <= void_nxt;
      err_r   <= err_nxt;
      ack_r   <= ack_nxt;
      pend_r  <= pend_nxt;
      pvoid_r <= pvoid_nxt;
      perr_r  <= perr_nxt;
      pack_r  <= pack_nxt;
      ist_r   <= ist_nxt;
      msk_r   <= msk_nxt;
      function_address_r <= function_address_nxt;
      reset_clears_address_feature_r  <= reset_clears_address_feature_nxt;
      sel_r   <= sel_nxt;
      rcnt_r  <= rcnt_nxt;
      for (int i = 0; i < NEP; i++) begin
        cnt_r[i]  <= cnt_nxt[i];
        sets_r[i] <= sets_nxt[i];
        wptr_r[i] <= wptr_nxt[i];
      end
    end
  end

  // ==========================================================
  // Checks
  void_stall_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && txn_end && !txn_setup && !txn_iso && rx_stall &&
    !setup_received_flag |=> void_r[$past(txn_ep)])
    else $error("void not set on stalled OUT");

  iso_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && txn_end && txn_iso && !txn_setup && !pend_r[txn_ep]
    |=> $stable(ack_r) && $stable(err_r))
    else $error("iso result applied before SOF");

  crc_err_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && txn_end && !txn_iso && txn_setup && txn_crc_err
    |=> err_r[$past(txn_ep)] && !ack_r[$past(txn_ep)])
    else $error("CRC failure not flagged");

  flag_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
    (err_r & ack_r) == '0)
    else $error("error and ack both set");

  done_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && txn_end && !txn_iso && txn_setup
    |=> ist_r[$past(txn_ep)])
    else $error("done bit not set");

  addr_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && usb_reset && reset_clears_address_feature_r |=> function_address == 7'h00)
    else $error("address not cleared on bus reset");

  sets_inc_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && lo_wr && !tx_set_done && sets_r[sel_r] != 2'h3
    |=> sets_r[$past(sel_r)] == $past(sets_r[sel_r]) + 2'h1)
    else $error("data-set count did not advance");

  setup_nak_a: assert property (@(posedge clk) disable iff (!rst_b)
    setup_received_flag |-> hs_nak && !hs_stall && !hs_ack)
    else $error("setup held but no NAK");

  wptr_inc_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && dat_wr |=> wptr_r[$past(sel_r)] ==
    FAW'($past(wptr_r[sel_r]) + 1'b1))
    else $error("write pointer did not advance");

endmodule

// ---- usb_host_model.sv ----
// Behavioural model of the USB host side and transmit fetch engine
module usb_host_model #(
  parameter int FAW = 6  // Log2 of FIFO bytes per endpoint
) (
  input  wire logic           clk,           // Core clock
  output logic                txn_end,       // Transaction end pulse
  output logic      [3:0]     txn_ep,        // Transaction endpoint
  output logic                txn_setup,     // SETUP, else OUT
  output logic                txn_iso,       // Isochronous
  output logic                txn_crc_err,   // CRC failure
  output logic                txn_stuff_err, // Stuffing error
  output logic                txn_fifo_err,  // FIFO error
  output logic                sof,           // Start of frame
  output logic                usb_reset,     // Bus reset
  output logic                tx_rd_en,      // Byte fetch
  output logic      [3:0]     tx_rd_ep,      // Fetch endpoint
  output logic      [FAW-1:0] tx_rd_ptr,     // Fetch pointer
  input  wire logic [7:0]     tx_rd_data,    // Fetched byte
  output logic                tx_set_done,   // Set sent pulse
  output logic      [3:0]     tx_set_ep      // Endpoint of set
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle levels at time zero
  initial begin
    {txn_end, sof, usb_reset, tx_rd_en, tx_set_done} = 5'h00;
    {txn_ep, txn_setup, txn_iso} = 6'h00;
    {txn_crc_err, txn_stuff_err, txn_fifo_err} = 3'h0;
    {tx_rd_ep, tx_rd_ptr, tx_set_ep} = '0;
  end

  // ==========================================================
  // One transaction; qualifiers flip after so stale values never pass
  task automatic txn(input logic [3:0] ep, input logic [4:0] k);
    @(posedge clk);
    txn_end <= 1'b1;
    txn_ep <= ep;
    {txn_setup, txn_iso, txn_crc_err, txn_stuff_err, txn_fifo_err} <= k;
    @(posedge clk);
    txn_end <= 1'b0;
    txn_ep <= ~ep;
    {txn_setup, txn_iso, txn_crc_err, txn_stuff_err, txn_fifo_err} <= ~k;
  endtask

  // Single-cycle pulses: 0 frame start, 1 bus reset, 2 set sent
  task automatic pulse(input int which, input logic [3:0] ep);
    @(posedge clk);
    if (which == 0) sof <= 1'b1;
    else if (which == 1) usb_reset <= 1'b1;
    else begin
      tx_set_done <= 1'b1;
      tx_set_ep <= ep;
    end
    @(posedge clk);
    {sof, usb_reset, tx_set_done} <= 3'h0;
    tx_set_ep <= ~ep;
  endtask

  // Fetch one byte; data is registered, valid the cycle after
  task automatic fetch(input logic [3:0] ep, input logic [FAW-1:0] p,
                       output logic [7:0] d);
    @(posedge clk);
    tx_rd_en <= 1'b1;
    tx_rd_ep <= ep;
    tx_rd_ptr <= p;
    @(posedge clk);
    tx_rd_en <= 1'b0;
    tx_rd_ptr <= ~p;
    @(negedge clk);
    d = tx_rd_data;
  endtask
endmodule
